/* nic_pkg.sv */
package nic_pkg;

	// ***************************************************************
	// Vector map and widths
	// ***************************************************************
	localparam int NUM_VEC = 14;
	localparam int NUM_EXT = 4;
	localparam int NUM_PER = 9;
	localparam int NUM_PRIO_REG = 4;
	localparam logic [3:0] VEC_TLI = 4'h0;
	localparam logic [3:0] VEC_EXT_BASE = 4'h2;
	localparam logic [3:0] VEC_PER_BASE = 4'h5;
	localparam logic [15:0] VEC_AREA_LO = 16'hffe0;
	localparam logic [15:0] VEC_ADDR_TLI = 16'hfffa;
	localparam logic [15:0] VEC_ADDR_TRAP = 16'hfffc;
	localparam logic [15:0] VEC_ADDR_RESET = 16'hfffe;
	localparam logic [13:0] HALT_CAP = 14'h00ff;

	// ***************************************************************
	// Priority codes, reset values, counts
	// ***************************************************************
	localparam logic [1:0] PRIO_L0 = 2'h2;
	localparam logic [1:0] PRIO_L3 = 2'h3;
	localparam logic [7:0] PRIO_REG_RST = 8'hff;
	localparam logic [7:0] PRIO_REG3_RO = 8'hf0;
	localparam logic [2:0] LVL_TLI = 3'h4;
	localparam logic [2:0] STACK_LAST = 3'h4;
	localparam logic [1:0] SENSE_LEVEL = 2'h0;
	localparam logic [1:0] SENSE_RISE = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;

	typedef struct packed {
		logic boundary;
		logic trap;
		logic return_from_isr_instr;
		logic unmask;
		logic mask;
		logic halt;
		logic wfi;
	} nic_cpu_cmd_s;

	typedef struct packed {
		logic valid;
		logic [3:0] idx;
		logic [2:0] lvl;
	} nic_win_s;

	// Two priority bits to numeric level 0..3
	function automatic logic [2:0] prio_level(input logic [1:0] bits);
		case (bits)
			2'h2: prio_level = 3'h0;
			2'h1: prio_level = 3'h1;
			2'h0: prio_level = 3'h2;
			default: prio_level = 3'h3;
		endcase
	endfunction

	// Vector address, ordered downward by hardware priority
	function automatic logic [15:0] vec_addr(input logic [3:0] idx);
		vec_addr = VEC_ADDR_TLI - {11'h000, idx, 1'b0};
	endfunction

endpackage

/* nic_prio_regs.sv */
`timescale 1ns/1ns
module nic_prio_regs (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [1:0] idx_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic [2*nic_pkg::NUM_VEC-1:0] prio_o
);

	logic [7:0] vector_priority_regs [0:nic_pkg::NUM_PRIO_REG-1];
	logic [7:0] merged;

	// ***************************************************************
	// Field merge: level 0 is never stored
	// ***************************************************************
	always_comb begin
		merged = vector_priority_regs[idx_i];
		for (int f = 0; f < 4; f++) begin
			if (wdata_i[2*f +: 2] != nic_pkg::PRIO_L0) begin
				merged[2*f +: 2] = wdata_i[2*f +: 2];
			end
		end
		if (idx_i == 2'h3) begin
			merged = merged | nic_pkg::PRIO_REG3_RO;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int r = 0; r < nic_pkg::NUM_PRIO_REG; r++) begin
				vector_priority_regs[r] <= nic_pkg::PRIO_REG_RST;
			end
		end else if (wr_i) begin
			vector_priority_regs[idx_i] <= merged;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= nic_pkg::PRIO_REG_RST;
		end else begin
			rdata_o <= vector_priority_regs[idx_i];
		end
	end

	always_comb begin
		for (int v = 0; v < nic_pkg::NUM_VEC; v++) begin
			prio_o[2*v +: 2] = vector_priority_regs[v/4][2*(v%4) +: 2];
		end
	end

endmodule // nic_prio_regs

/* nic_arbiter.sv */
`timescale 1ns/1ns
module nic_arbiter (
	input wire logic [nic_pkg::NUM_VEC-1:0] req_i,
	input wire logic [2*nic_pkg::NUM_VEC-1:0] prio_i,
	input wire logic halt_only_i,
	output nic_pkg::nic_win_s win_o
);

	logic [nic_pkg::NUM_VEC-1:0] cand;
	logic [2:0] lvl;

	// ***************************************************************
	// Software level first, then lowest index
	// ***************************************************************
	always_comb begin
		cand = halt_only_i ? (req_i & nic_pkg::HALT_CAP) : req_i;
		win_o = '0;
		lvl = 3'h0;
		for (int v = nic_pkg::NUM_VEC - 1; v >= 0; v--) begin
			if (v == 0) begin
				lvl = nic_pkg::LVL_TLI;
			end else begin
				lvl = nic_pkg::prio_level(prio_i[2*v +: 2]);
			end
			// Equal level: later (lower) index overrides, so one winner
			if (cand[v] && (!win_o.valid || lvl >= win_o.lvl)) begin
				win_o.valid = 1'b1;
				win_o.idx = 4'(v);
				win_o.lvl = lvl;
			end
		end
	end

endmodule // nic_arbiter

/* nic_core.sv */
`timescale 1ns/1ns
module nic_core (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire nic_pkg::nic_cpu_cmd_s cpu_cmd_i,
	input wire logic cc_pop_valid_i,
	input wire logic [7:0] cc_pop_data_i,
	input wire logic prio_wr_i,
	input wire logic [1:0] prio_idx_i,
	input wire logic [7:0] prio_wdata_i,
	input wire logic top_level_irq_i,
	input wire logic top_level_irq_rise_i,
	input wire logic [4*nic_pkg::NUM_EXT-1:0] ext_pin_i,
	input wire logic [4*nic_pkg::NUM_EXT-1:0] ext_pin_sel_i,
	input wire logic [2*nic_pkg::NUM_EXT-1:0] ext_irq_sense_ctrl_i,
	input wire logic [nic_pkg::NUM_PER-1:0] per_flag_i,
	input wire logic [nic_pkg::NUM_PER-1:0] per_en_i,
	input wire logic [nic_pkg::NUM_PER-1:0] per_clr_i,
	output logic cur_prio_hi_bit_o,
	output logic cur_prio_lo_bit_o,
	output logic busy_o,
	output logic stack_push_o,
	output logic stack_pop_o,
	output logic [2:0] stack_sel_o,
	output logic vec_load_o,
	output logic [15:0] vector_addr_o,
	output logic wake_o,
	output logic halted_o,
	output logic waiting_o,
	output logic [nic_pkg::NUM_VEC-1:0] pending_o,
	output logic [7:0] prio_rdata_o
);

	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_IDLE = 3'b001,
		ST_PUSH = 3'b010,
		ST_VECT = 3'b011,
		ST_POP = 3'b100
	} nic_state_e;

	// ***************************************************************
	// Declarations
	// ***************************************************************
	nic_state_e state;
	logic [1:0] cur_prio;
	logic [2:0] cnt;
	logic [15:0] tgt_addr;
	logic [1:0] tgt_prio;
	logic [3:0] tgt_idx;
	logic tgt_is_vec;
	logic tli_prev;
	logic tli_latch;
	logic [nic_pkg::NUM_EXT-1:0] ext_prev;
	logic [nic_pkg::NUM_EXT-1:0] ext_latch;
	logic [nic_pkg::NUM_EXT-1:0] ext_line;
	logic [nic_pkg::NUM_EXT-1:0] ext_req;
	logic [nic_pkg::NUM_PER-1:0] per_latch;
	logic [nic_pkg::NUM_VEC-1:0] req;
	logic [2*nic_pkg::NUM_VEC-1:0] vec_prio;
	logic halt_exit;
	logic take_trap;
	logic take_int;
	logic entry;
	logic [nic_pkg::NUM_VEC-1:0] clr_on_entry;
	nic_pkg::nic_win_s win;

	// ***************************************************************
	// Priority registers and arbiter
	// ***************************************************************
	nic_prio_regs u_prio (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.wr_i(prio_wr_i),
		.idx_i(prio_idx_i),
		.wdata_i(prio_wdata_i),
		.rdata_o(prio_rdata_o),
		.prio_o(vec_prio)
	);

	nic_arbiter u_arb (
		.req_i(req),
		.prio_i(vec_prio),
		.halt_only_i(halt_exit),
		.win_o(win)
	);

	// ***************************************************************
	// Request sources
	// ***************************************************************
	always_comb begin
		for (int g = 0; g < nic_pkg::NUM_EXT; g++) begin
			ext_line[g] = |(ext_pin_i[4*g +: 4] & ext_pin_sel_i[4*g +: 4]);
		end
	end

	always_comb begin
		for (int g = 0; g < nic_pkg::NUM_EXT; g++) begin
			if (ext_irq_sense_ctrl_i[2*g +: 2] == nic_pkg::SENSE_LEVEL) begin
				ext_req[g] = ext_line[g];
			end else begin
				ext_req[g] = ext_latch[g];
			end
		end
	end

	always_comb begin
		req = '0;
		req[nic_pkg::VEC_TLI] = tli_latch;
		for (int g = 0; g < nic_pkg::NUM_EXT; g++) begin
			req[int'(nic_pkg::VEC_EXT_BASE) + g] = ext_req[g];
		end
		req[1] = per_latch[0];
		for (int p = 1; p < nic_pkg::NUM_PER; p++) begin
			req[int'(nic_pkg::VEC_PER_BASE) + p] = per_latch[p];
		end
	end

	// Entered vector; only the top level and external latched requests are consumed by it
	always_comb begin
		clr_on_entry = '0;
		if (entry && tgt_is_vec) begin
			clr_on_entry[tgt_idx] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			tli_prev <= 1'b0;
			tli_latch <= 1'b0;
		end else begin
			tli_prev <= top_level_irq_i;
			if (top_level_irq_rise_i ? (top_level_irq_i && !tli_prev)
				: (!top_level_irq_i && tli_prev)) begin
				tli_latch <= 1'b1;
			end else if (clr_on_entry[nic_pkg::VEC_TLI]) begin
				tli_latch <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ext_prev <= '0;
			ext_latch <= '0;
		end else begin
			ext_prev <= ext_line;
			for (int g = 0; g < nic_pkg::NUM_EXT; g++) begin
				if ((ext_irq_sense_ctrl_i[2*g +: 2] != nic_pkg::SENSE_FALL
					&& ext_line[g] && !ext_prev[g])
					|| (ext_irq_sense_ctrl_i[2*g +: 2] != nic_pkg::SENSE_RISE
					&& ext_irq_sense_ctrl_i[2*g +: 2] != nic_pkg::SENSE_LEVEL
					&& !ext_line[g] && ext_prev[g])) begin
					ext_latch[g] <= 1'b1;
				end else if (clr_on_entry[int'(nic_pkg::VEC_EXT_BASE) + g]) begin
					ext_latch[g] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			per_latch <= '0;
		end else begin
			for (int p = 0; p < nic_pkg::NUM_PER; p++) begin
				if (per_flag_i[p] && per_en_i[p]) begin
					per_latch[p] <= 1'b1;
				end else if (per_clr_i[p] || !per_en_i[p]) begin
					per_latch[p] <= 1'b0;
				end
			end
		end
	end

	// ***************************************************************
	// Service decision at the instruction boundary
	// ***************************************************************
	always_comb begin
		take_trap = (state == ST_IDLE) && cpu_cmd_i.boundary && cpu_cmd_i.trap;
		take_int = (state == ST_IDLE) && cpu_cmd_i.boundary && !cpu_cmd_i.trap
			&& win.valid
			&& (win.lvl > nic_pkg::prio_level(cur_prio));
		entry = (state == ST_VECT);
	end

	// ***************************************************************
	// Stacking, vectoring and return sequencer
	// ***************************************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_RESET;
			cnt <= 3'h0;
			tgt_addr <= nic_pkg::VEC_ADDR_RESET;
			tgt_prio <= nic_pkg::PRIO_L3;
			tgt_idx <= 4'h0;
			tgt_is_vec <= 1'b0;
		end else begin
			case (state)
				ST_RESET: begin
					state <= ST_VECT; // reset does not stack
				end
				ST_IDLE: begin
					cnt <= 3'h0;
					if (take_trap) begin
						tgt_addr <= nic_pkg::VEC_ADDR_TRAP;
						tgt_prio <= nic_pkg::PRIO_L3;
						tgt_is_vec <= 1'b0;
						state <= ST_PUSH;
					end else if (take_int) begin
						tgt_addr <= nic_pkg::vec_addr(win.idx);
						tgt_idx <= win.idx;
						tgt_is_vec <= 1'b1;
						if (win.idx == nic_pkg::VEC_TLI) begin
							tgt_prio <= nic_pkg::PRIO_L3;
						end else begin
							tgt_prio <= vec_prio[2*win.idx +: 2];
						end
						state <= ST_PUSH;
					end else if (cpu_cmd_i.return_from_isr_instr) begin
						state <= ST_POP;
					end
				end
				ST_PUSH: begin
					cnt <= cnt + 3'h1;
					if (cnt == nic_pkg::STACK_LAST) begin
						state <= ST_VECT;
					end
				end
				ST_VECT: begin
					state <= ST_IDLE;
				end
				default: begin
					cnt <= cnt + 3'h1;
					if (cnt == nic_pkg::STACK_LAST) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ***************************************************************
	// Current priority bits
	// ***************************************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cur_prio <= nic_pkg::PRIO_L3;
		end else if (state == ST_VECT) begin
			cur_prio <= tgt_prio;
		end else if (cc_pop_valid_i) begin
			cur_prio <= {cc_pop_data_i[5], cc_pop_data_i[3]};
		end else if (cpu_cmd_i.mask) begin
			cur_prio <= nic_pkg::PRIO_L3;
		end else if (cpu_cmd_i.unmask || cpu_cmd_i.halt || cpu_cmd_i.wfi) begin
			cur_prio <= nic_pkg::PRIO_L0;
		end
	end

	// ***************************************************************
	// Low power modes
	// ***************************************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			halted_o <= 1'b0;
			waiting_o <= 1'b0;
			wake_o <= 1'b0;
			halt_exit <= 1'b0;
		end else begin
			wake_o <= 1'b0;
			if (entry) begin
				halt_exit <= 1'b0;
			end
			if (halted_o) begin
				if (|(req & nic_pkg::HALT_CAP)) begin
					halted_o <= 1'b0;
					wake_o <= 1'b1;
					halt_exit <= 1'b1;
				end
			end else if (waiting_o) begin
				if (|req) begin
					waiting_o <= 1'b0;
					wake_o <= 1'b1;
				end
			end else if (cpu_cmd_i.halt) begin
				halted_o <= 1'b1;
			end else if (cpu_cmd_i.wfi) begin
				waiting_o <= 1'b1;
			end
		end
	end

	// ***************************************************************
	// CPU facing outputs
	// ***************************************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			stack_push_o <= 1'b0;
			stack_pop_o <= 1'b0;
			stack_sel_o <= 3'h0;
			vec_load_o <= 1'b0;
			vector_addr_o <= nic_pkg::VEC_ADDR_RESET;
			busy_o <= 1'b1;
		end else begin
			stack_push_o <= (state == ST_PUSH);
			stack_pop_o <= (state == ST_POP);
			stack_sel_o <= (state == ST_POP) ? (nic_pkg::STACK_LAST - cnt) : cnt;
			vec_load_o <= (state == ST_VECT);
			vector_addr_o <= tgt_addr;
			busy_o <= (state != ST_IDLE);
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cur_prio_hi_bit_o <= 1'b1;
			cur_prio_lo_bit_o <= 1'b1;
			pending_o <= '0;
		end else begin
			cur_prio_hi_bit_o <= cur_prio[1];
			cur_prio_lo_bit_o <= cur_prio[0];
			pending_o <= req;
		end
	end

endmodule // nic_core

/* nic_cpu_model.sv */
`timescale 1ns/1ns
module nic_cpu_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [2:0] sel_i,
	input wire logic prio_hi_i,
	input wire logic prio_lo_i,
	output logic cc_pop_valid_o,
	output logic [7:0] cc_pop_data_o
);
	// ****
	// Stack of saved condition code bytes
	// ****
	logic [7:0] cc_stack [8];
	logic [2:0] sp;
	// Depth wraps silently, no overflow flag
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sp <= 3'h0;
			cc_pop_valid_o <= 1'b0;
			cc_pop_data_o <= 8'h00;
		end else begin
			cc_pop_valid_o <= pop_i && sel_i == 3'h4;
			cc_pop_data_o <= ~cc_pop_data_o;
			if (push_i && sel_i == 3'h4) begin
				cc_stack[sp] <= {2'h3, prio_hi_i, 1'b0, prio_lo_i, 3'h0};
				sp <= sp + 3'h1;
			end
			if (pop_i && sel_i == 3'h4) begin
				cc_pop_data_o <= cc_stack[sp - 3'h1];
				sp <= sp - 3'h1;
			end
		end
	end
endmodule // nic_cpu_model

/* nic_core_properties.sv */
`timescale 1ns/1ns
module nic_props (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire nic_pkg::nic_cpu_cmd_s cpu_cmd_i,
	input wire logic cc_pop_valid_i,
	input wire logic cur_prio_hi_bit_o,
	input wire logic cur_prio_lo_bit_o,
	input wire logic busy_o,
	input wire logic stack_push_o,
	input wire logic stack_pop_o,
	input wire logic [2:0] stack_sel_o,
	input wire logic vec_load_o,
	input wire logic [15:0] vector_addr_o
);
	// ****
	// Sequencer and level properties
	// ****
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire logic [1:0] lvl = {cur_prio_hi_bit_o, cur_prio_lo_bit_o};
	sequence s_push_tail;
		stack_push_o && stack_sel_o == 3'h1 ##1 stack_push_o && stack_sel_o == 3'h2
		##1 stack_push_o && stack_sel_o == 3'h3 ##1 stack_push_o && stack_sel_o == 3'h4;
	endsequence
	sequence s_pop_tail;
		stack_pop_o && stack_sel_o == 3'h3 ##1 stack_pop_o && stack_sel_o == 3'h2
		##1 stack_pop_o && stack_sel_o == 3'h1 ##1 stack_pop_o && stack_sel_o == 3'h0;
	endsequence
	a_push_order: assert property (stack_push_o && stack_sel_o == 3'h0 |=> s_push_tail)
		else $error("push order wrong");
	a_push_then_vec: assert property (stack_push_o && stack_sel_o == 3'h4 |=> vec_load_o)
		else $error("no vector load after push");
	a_pop_order: assert property (stack_pop_o && stack_sel_o == 3'h4 |=> s_pop_tail)
		else $error("pop order wrong");
	a_vec_area: assert property (vec_load_o |-> vector_addr_o >= nic_pkg::VEC_AREA_LO)
		else $error("vector outside area");
	a_nmi_level: assert property (vec_load_o && (vector_addr_o == nic_pkg::VEC_ADDR_TRAP
		|| vector_addr_o == nic_pkg::VEC_ADDR_TLI) |=> lvl == nic_pkg::PRIO_L3)
		else $error("top entry level wrong");
	a_mask_level: assert property (cpu_cmd_i.mask && !cc_pop_valid_i
		|-> ##2 ($past(vec_load_o) || lvl == nic_pkg::PRIO_L3))
		else $error("mask level wrong");
	a_unmask_level: assert property ((cpu_cmd_i.unmask || cpu_cmd_i.halt || cpu_cmd_i.wfi)
		&& !cpu_cmd_i.mask && !cc_pop_valid_i
		|-> ##2 ($past(vec_load_o) || lvl == nic_pkg::PRIO_L0))
		else $error("unmask level wrong");
	a_idle_quiet: assert property (!busy_o |-> !stack_push_o && !stack_pop_o && !vec_load_o)
		else $error("stack activity while idle");
	a_reset_vec: assert property ($fell(rst_i) |=> ##1 (vec_load_o
		&& vector_addr_o == nic_pkg::VEC_ADDR_RESET && lvl == nic_pkg::PRIO_L3))
		else $error("reset entry wrong");
endmodule // nic_props
bind nic_core nic_props u_props (.clk_sys_i, .rst_i, .cpu_cmd_i, .cc_pop_valid_i,
	.cur_prio_hi_bit_o, .cur_prio_lo_bit_o, .busy_o, .stack_push_o, .stack_pop_o,
	.stack_sel_o, .vec_load_o, .vector_addr_o);

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	// ****
	// Bench for the interrupt controller
	// ****
	localparam logic [6:0] C_B = 7'h40;
	localparam logic [6:0] C_T = 7'h60;
	localparam logic [6:0] C_I = 7'h50;
	localparam logic [6:0] C_U = 7'h08;
	localparam logic [6:0] C_M = 7'h04;
	localparam logic [6:0] C_H = 7'h02;
	localparam logic [6:0] C_W = 7'h01;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	nic_pkg::nic_cpu_cmd_s cpu_cmd_i = '0;
	logic cc_pop_valid_i;
	logic [7:0] cc_pop_data_i;
	logic prio_wr_i = 1'b0;
	logic [1:0] prio_idx_i = 2'h0;
	logic [7:0] prio_wdata_i = 8'h00;
	logic top_level_irq_i = 1'b0;
	logic top_level_irq_rise_i = 1'b1;
	logic [15:0] ext_pin_i = 16'h0000;
	logic [15:0] ext_pin_sel_i = 16'h0003;
	logic [7:0] ext_irq_sense_ctrl_i = 8'h01;
	logic [8:0] per_flag_i = 9'h000;
	logic [8:0] per_en_i = 9'h000;
	logic [8:0] per_clr_i = 9'h000;
	logic cur_prio_hi_bit_o, cur_prio_lo_bit_o, busy_o, stack_push_o, stack_pop_o;
	logic vec_load_o, wake_o, halted_o, waiting_o;
	logic [2:0] stack_sel_o;
	logic [15:0] vector_addr_o;
	logic [13:0] pending_o;
	logic [7:0] prio_rdata_o;
	wire logic [1:0] lvl = {cur_prio_hi_bit_o, cur_prio_lo_bit_o};
	int err_count = 0;
	int total_checks = 0;
	// Index, write data, expected read back
	logic [17:0] rows [5] = '{{2'h0, 8'hcf, 8'hcf}, {2'h0, 8'h64, 8'h44},
		{2'h1, 8'h55, 8'h55}, {2'h2, 8'haa, 8'hff}, {2'h3, 8'h0c, 8'hfc}};
	always #20 clk_sys_i = ~clk_sys_i;
	nic_core dut_u (.clk_sys_i, .rst_i, .cpu_cmd_i, .cc_pop_valid_i, .cc_pop_data_i,
		.prio_wr_i, .prio_idx_i, .prio_wdata_i, .top_level_irq_i, .top_level_irq_rise_i,
		.ext_pin_i, .ext_pin_sel_i, .ext_irq_sense_ctrl_i, .per_flag_i, .per_en_i,
		.per_clr_i, .cur_prio_hi_bit_o, .cur_prio_lo_bit_o, .busy_o, .stack_push_o,
		.stack_pop_o, .stack_sel_o, .vec_load_o, .vector_addr_o, .wake_o, .halted_o,
		.waiting_o, .pending_o, .prio_rdata_o);
	nic_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .push_i(stack_push_o),
		.pop_i(stack_pop_o), .sel_i(stack_sel_o), .prio_hi_i(cur_prio_hi_bit_o),
		.prio_lo_i(cur_prio_lo_bit_o), .cc_pop_valid_o(cc_pop_valid_i),
		.cc_pop_data_o(cc_pop_data_i));
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tmo(input string n);
		err_count++;
		$display("ERROR %s expected done seen timeout", n);
		wrap_up();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic go(input logic [6:0] c);
		cpu_cmd_i = nic_pkg::nic_cpu_cmd_s'(c);
		tick(1);
		cpu_cmd_i = '0;
		tick(1);
	endtask
	task automatic idle();
		int i;
		for (i = 0; i < 20 && busy_o !== 1'b0; i++) tick(1);
		if (busy_o !== 1'b0) tmo("busy");
	endtask
	task automatic serve(input logic [6:0] c, input logic [15:0] a, input logic [1:0] p);
		int i;
		go(c);
		for (i = 0; i < 20 && vec_load_o !== 1'b1; i++) tick(1);
		if (vec_load_o !== 1'b1) tmo("entry");
		chk("vector", vector_addr_o, a);
		tick(1);
		chk("entry level", 16'(lvl), 16'(p));
		idle();
	endtask
	task automatic ret(input logic [1:0] p);
		go(C_I);
		tick(1);
		idle();
		tick(2);
		chk("restored level", 16'(lvl), 16'(p));
	endtask
	task automatic clr(input logic [8:0] m);
		per_clr_i = m;
		tick(1);
		per_clr_i = 9'h000;
		tick(2);
	endtask
	initial begin
		int i;
		tick(3);
		chk("reset level", 16'(lvl), 16'h0003);
		chk("reset prio reg", 16'(prio_rdata_o), 16'h00ff);
		rst_i = 1'b0;
		tick(4);
		chk("boot vector", vector_addr_o, nic_pkg::VEC_ADDR_RESET);
		for (i = 0; i < 5; i++) begin
			{prio_idx_i, prio_wdata_i} = rows[i][17:8];
			prio_wr_i = 1'b1;
			tick(1);
			prio_wr_i = 1'b0;
			tick(1);
			chk("prio reg", 16'(prio_rdata_o), 16'(rows[i][7:0]));
		end
		per_flag_i = 9'h009;
		per_en_i = 9'h001;
		tick(1);
		per_flag_i = 9'h000;
		tick(3);
		chk("latched", 16'(pending_o), 16'h0002);
		go(C_B);
		tick(8);
		chk("masked", vector_addr_o, 16'hfffe);
		clr(9'h001);
		chk("discarded", 16'(pending_o), 16'h0000);
		per_flag_i = 9'h086;
		per_en_i = 9'h086;
		go(C_U);
		chk("unmask", 16'(lvl), 16'h0002);
		serve(C_B, 16'hffe2, 2'h0);
		go(C_B);
		tick(8);
		chk("nested refusal", vector_addr_o, 16'hffe2);
		serve(C_T, nic_pkg::VEC_ADDR_TRAP, 2'h3);
		top_level_irq_i = 1'b1;
		tick(2);
		serve(C_B, nic_pkg::VEC_ADDR_TLI, 2'h3);
		top_level_irq_i = 1'b0;
		ret(2'h3);
		ret(2'h0);
		per_flag_i = 9'h006;
		clr(9'h080);
		ret(2'h2);
		serve(C_B, 16'hffee, 2'h1);
		per_flag_i = 9'h000;
		clr(9'h1ff);
		ret(2'h2);
		go(C_M);
		chk("mask", 16'(lvl), 16'h0003);
		ext_pin_i = 16'h0002;
		tick(3);
		ext_pin_i = 16'h0000;
		tick(2);
		chk("ext latched", 16'(pending_o), 16'h0004);
		go(C_U);
		serve(C_B, 16'hfff6, 2'h0);
		chk("ext cleared", 16'(pending_o), 16'h0000);
		ret(2'h2);
		go(C_W);
		chk("waiting", 16'(waiting_o), 16'h0001);
		per_flag_i = 9'h100;
		per_en_i = 9'h100;
		for (i = 0; i < 20 && waiting_o !== 1'b0; i++) tick(1);
		if (waiting_o !== 1'b0) tmo("wait wake");
		chk("wait wake", 16'(wake_o), 16'h0001);
		go(C_H);
		tick(4);
		chk("halted", 16'(halted_o), 16'h0001);
		ext_pin_i = 16'h0001;
		for (i = 0; i < 20 && halted_o !== 1'b0; i++) tick(1);
		if (halted_o !== 1'b0) tmo("wake");
		chk("halt wake", 16'(wake_o), 16'h0001);
		serve(C_B, 16'hfff6, 2'h0);
		serve(C_B, 16'hffe0, 2'h3);
		top_level_irq_rise_i = 1'b0;
		top_level_irq_i = 1'b1;
		tick(2);
		chk("no rise", 16'(pending_o[0]), 16'h0000);
		top_level_irq_i = 1'b0;
		tick(2);
		chk("fall latched", 16'(pending_o[0]), 16'h0001);
		serve(C_B, nic_pkg::VEC_ADDR_TLI, 2'h3);
		wrap_up();
	end
endmodule // tb_top
